// ### hdl/psar_latch_bit.sv
// Latch-high or latch-low status bit reloaded with the live level by a read
`timescale 1ns/1ns
`default_nettype none
module psar_latch_bit #(
	parameter bit LATCH_HIGH = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic live,
	input wire logic readDone,
	output logic held
);
	// ********************************************************
	// Sticky level
	// ********************************************************
	logic event_now;
	logic next_held;
	assign event_now = LATCH_HIGH ? live : ~live;
	// Event beats the read reload; reload shows the live level
	assign next_held = event_now ? LATCH_HIGH :
		(readDone ? live : held);

	// Held value register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			held <= 1'b0;
		end else begin
			held <= next_held;
		end
	end
endmodule : psar_latch_bit
`default_nettype wire

// ### hdl/psar_pkg.sv
// Constants for the PHY status, identifier and advertisement registers
package psar_pkg;
	// ********************************************************
	// Register indexes
	// ********************************************************
	localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
	localparam logic [4:0] IDX_IDENT_HIGH = 5'h02;
	localparam logic [4:0] IDX_IDENT_LOW = 5'h03;
	localparam logic [4:0] IDX_ADVERTISE = 5'h04;

	// ********************************************************
	// Basic status fields
	// ********************************************************
	localparam int ST_T4 = 15;
	localparam int ST_TX_FD = 14;
	localparam int ST_TX_HD = 13;
	localparam int ST_10_FD = 12;
	localparam int ST_10_HD = 11;
	localparam int ST_AN_DONE = 5;
	localparam int ST_REM_FAULT = 4;
	localparam int ST_AN_ABLE = 3;
	localparam int ST_LINK = 2;
	localparam int ST_JABBER = 1;
	localparam int ST_EXT_CAP = 0;

	// ********************************************************
	// Advertisement fields
	// ********************************************************
	localparam int ADV_REM_FAULT = 13;
	localparam int ADV_PAUSE_LO = 10;
	localparam int ADV_ABIL_LO = 5;
	localparam int ADV_SEL_LO = 0;
	localparam logic [15:0] ADV_WR_MASK = 16'h2de0 | 16'h001f;

	// Pause encodings
	localparam logic [1:0] PAUSE_NONE = 2'h0;
	localparam logic [1:0] PAUSE_SYM = 2'h1;
	localparam logic [1:0] PAUSE_ASYM = 2'h2;
	localparam logic [1:0] PAUSE_BOTH = 2'h3;

	// ********************************************************
	// Reset values
	// ********************************************************
	// Identifier defaults are arbitrary neutral values
	localparam logic [15:0] RST_IDENT_HIGH = 16'h1234;
	localparam logic [5:0] RST_OUI_HI = 6'h15;
	localparam logic [5:0] RST_MODEL = 6'h2a;
	localparam logic [3:0] RST_REVISION = 4'h1;
	localparam logic [15:0] RST_ADVERTISE = 16'h01e1;

	// Manager states
	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_READ = 2'b01,
		PS_WRITE = 2'b11
	} psar_state_t;
endpackage : psar_pkg

// ### hdl/psar_regs.sv
// PHY basic status, identifier and advertisement registers
`timescale 1ns/1ns
`default_nettype none
module psar_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mgmtRead,
	input wire logic mgmtWrite,
	input wire logic [4:0] mgmtIndex,
	input wire logic [15:0] mgmtWdata,
	input wire logic anComplete,
	input wire logic remoteFault,
	input wire logic linkUp,
	input wire logic jabber,
	input wire logic partnerSym,
	input wire logic partnerAsym,
	output logic [15:0] mgmtRdata,
	output logic mgmtAck,
	output logic mgmtHit,
	output logic [15:0] advertWord,
	output logic [1:0] pauseResolved
);
	import psar_pkg::*;

	// ********************************************************
	// State and storage
	// ********************************************************
	psar_state_t state;
	psar_state_t next_state;
	logic anDone;
	logic [15:0] identHigh;
	logic [5:0] ouiHigh;
	logic [5:0] modelNum;
	logic [3:0] revNum;
	logic [15:0] advertise;
	logic remFaultHeld;
	logic linkHeld;
	logic jabberHeld;

	// ********************************************************
	// Index decode
	// ********************************************************
	wire hitStatus = (mgmtIndex == IDX_BASIC_STATUS);
	wire hitIdHigh = (mgmtIndex == IDX_IDENT_HIGH);
	wire hitIdLow = (mgmtIndex == IDX_IDENT_LOW);
	wire hitAdv = (mgmtIndex == IDX_ADVERTISE);
	wire hitAny = hitStatus | hitIdHigh | hitIdLow | hitAdv;
	wire takeRead = (state == PS_IDLE) & mgmtRead;
	wire takeWrite = (state == PS_IDLE) & mgmtWrite & ~mgmtRead;
	wire statusReadDone = takeRead & hitStatus;

	// ********************************************************
	// Latched status bits
	// ********************************************************
	// remote fault latch
	psar_latch_bit #(.LATCH_HIGH(1'b1)) u_remfault (
		.mclk(mclk),
		.rst_n(rst_n),
		.live(remoteFault),
		.readDone(statusReadDone),
		.held(remFaultHeld)
	);

	psar_latch_bit #(.LATCH_HIGH(1'b0)) u_link (
		.mclk(mclk),
		.rst_n(rst_n),
		.live(linkUp),
		.readDone(statusReadDone),
		.held(linkHeld)
	);

	psar_latch_bit #(.LATCH_HIGH(1'b1)) u_jabber (
		.mclk(mclk),
		.rst_n(rst_n),
		.live(jabber),
		.readDone(statusReadDone),
		.held(jabberHeld)
	);

	// ********************************************************
	// Status word assembly
	// ********************************************************
	logic [15:0] statusWord;
	always_comb begin
		statusWord = 16'h0000;
		statusWord[ST_T4] = 1'b0;
		statusWord[ST_TX_FD] = 1'b1;
		statusWord[ST_TX_HD] = 1'b1;
		statusWord[ST_10_FD] = 1'b1;
		statusWord[ST_10_HD] = 1'b1;
		statusWord[ST_AN_DONE] = anDone;
		statusWord[ST_REM_FAULT] = remFaultHeld;
		statusWord[ST_AN_ABLE] = 1'b1;
		statusWord[ST_LINK] = linkHeld;
		statusWord[ST_JABBER] = jabberHeld;
		statusWord[ST_EXT_CAP] = 1'b1;
	end

	// Read data select, unmapped index reads zero
	wire [15:0] identLowWord = {ouiHigh, modelNum, revNum};
	wire [15:0] readMux = hitStatus ? statusWord :
		hitIdHigh ? identHigh :
		hitIdLow ? identLowWord :
		hitAdv ? advertise : 16'h0000;

	// ********************************************************
	// Pause resolution
	// ********************************************************
	wire [1:0] advPause = advertise[ADV_PAUSE_LO +: 2];
	logic [1:0] next_pause;
	always_comb begin
		case (advPause)
			PAUSE_NONE: next_pause = PAUSE_NONE;
			PAUSE_SYM: next_pause = partnerSym ? PAUSE_SYM : PAUSE_NONE;
			PAUSE_ASYM: next_pause = (partnerSym & partnerAsym) ?
				PAUSE_ASYM : PAUSE_NONE;
			PAUSE_BOTH: next_pause = partnerSym ? PAUSE_SYM :
				(partnerAsym ? PAUSE_ASYM : PAUSE_NONE);
			default: next_pause = PAUSE_NONE;
		endcase
	end

	// ********************************************************
	// Manager state machine
	// ********************************************************
	always_comb begin
		case (state)
			PS_IDLE: next_state = takeRead ? PS_READ :
				(takeWrite ? PS_WRITE : PS_IDLE);
			PS_READ: next_state = PS_IDLE;
			PS_WRITE: next_state = PS_IDLE;
			default: next_state = PS_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Answer registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mgmtRdata <= 16'h0000;
			mgmtAck <= 1'b0;
			mgmtHit <= 1'b0;
		end else begin
			mgmtAck <= takeRead | takeWrite;
			if (takeRead | takeWrite) begin
				mgmtHit <= hitAny;
			end
			if (takeRead) begin
				mgmtRdata <= readMux;
			end
		end
	end

	// ********************************************************
	// Writable registers
	// ********************************************************
	// first identifier write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			identHigh <= RST_IDENT_HIGH;
		end else if (takeWrite & hitIdHigh) begin
			identHigh <= mgmtWdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ouiHigh <= RST_OUI_HI;
			modelNum <= RST_MODEL;
		end else if (takeWrite & hitIdLow) begin
			ouiHigh <= mgmtWdata[15:10];
			modelNum <= mgmtWdata[9:4];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			revNum <= RST_REVISION;
		end else if (takeWrite & hitIdLow) begin
			revNum <= mgmtWdata[3:0];
		end
	end

	wire [15:0] advNext = mgmtWdata & ADV_WR_MASK;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			advertise <= RST_ADVERTISE;
		end else if (takeWrite & hitAdv) begin
			advertise <= advNext;
		end
	end

	// ********************************************************
	// Autoneg completion and outputs
	// ********************************************************
	// completion level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			anDone <= 1'b0;
		end else begin
			anDone <= anComplete;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pauseResolved <= PAUSE_NONE;
		end else if (!anComplete) begin
			pauseResolved <= PAUSE_NONE;
		end else if (!anDone) begin
			pauseResolved <= next_pause;
		end
	end

	// Advertised word to the autoneg engine
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			advertWord <= RST_ADVERTISE;
		end else begin
			advertWord <= advertise;
		end
	end
endmodule : psar_regs
`default_nettype wire

// ### testbench/phy_status_id_advert_regs_tb.sv
// Self-checking bench for the PHY status and advertisement registers
`timescale 1ns/1ns
`default_nettype none
module phy_status_id_advert_regs_tb;
	import psar_pkg::*;
	logic mclk, rst_n, anComplete, remoteFault, linkUp, jabber;
	logic partnerSym, partnerAsym;
	wire logic mgmtRead, mgmtWrite, mgmtAck, mgmtHit;
	wire logic [4:0] mgmtIndex;
	wire logic [15:0] mgmtWdata, mgmtRdata, advertWord;
	wire logic [1:0] pauseResolved;
	logic [15:0] rd, wd, shadow [0:7];
	logic [4:0] idx;
	int nFail, totalChecks, cyc, seed, i;
	// Design and its management partner
	psar_regs dut_u (.mclk, .rst_n, .mgmtRead, .mgmtWrite, .mgmtIndex,
		.mgmtWdata, .anComplete, .remoteFault, .linkUp, .jabber, .partnerSym,
		.partnerAsym, .mgmtRdata, .mgmtAck, .mgmtHit, .advertWord,
		.pauseResolved);
	psar_mac_model mac_u (.mclk, .mgmtAck, .mgmtRdata, .mgmtRead,
		.mgmtWrite, .mgmtIndex, .mgmtWdata);
	always #20 mclk = ~mclk;
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		totalChecks++;
		if (seen !== exp) begin
			nFail++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic testDone();
		if (nFail == 0 && totalChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : testDone
	// Resolved pause for local and partner abilities
	function automatic logic [1:0] expPause(input logic [1:0] adv,
		input logic s, a);
		case (adv)
			PAUSE_BOTH: return s ? PAUSE_SYM : (a ? PAUSE_ASYM : PAUSE_NONE);
			PAUSE_SYM: return s ? PAUSE_SYM : PAUSE_NONE;
			PAUSE_ASYM: return (s && a) ? PAUSE_ASYM : PAUSE_NONE;
			default: return PAUSE_NONE;
		endcase
	endfunction : expPause
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 5000) begin
			nFail++;
			testDone();
		end
	end
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		seed = 74822;
		{anComplete, remoteFault, linkUp, jabber, partnerSym, partnerAsym} = 6'h0;
		for (i = 0; i < 8; i++) shadow[i] = 16'h0;
		shadow[1] = 16'h7809;
		shadow[2] = RST_IDENT_HIGH;
		shadow[3] = {RST_OUI_HI, RST_MODEL, RST_REVISION};
		shadow[4] = 16'h01e1;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		// Reset values
		for (i = 1; i < 5; i++) begin
			mac_u.xfer(1'b0, i[4:0], 16'h0, rd);
			chk("reset value", rd, shadow[i]);
		end
		chk("advert copy", advertWord, 16'h01e1);
		// Latched events shown once, then reloaded
		linkUp <= 1'b1;
		jabber <= 1'b1;
		remoteFault <= 1'b1;
		@(posedge mclk);
		jabber <= 1'b0;
		remoteFault <= 1'b0;
		repeat (3) @(posedge mclk);
		mac_u.xfer(1'b0, IDX_BASIC_STATUS, 16'h0, rd);
		chk("latched status", rd, 16'h781b);
		mac_u.xfer(1'b0, IDX_BASIC_STATUS, 16'h0, rd);
		chk("reloaded status", rd, 16'h780d);
		shadow[1] = 16'h780d;
		// Random writes and read back, unmapped indexes included
		for (i = 0; i < 24; i++) begin
			idx = 5'({$random(seed)} % 8);
			wd = 16'($random(seed));
			mac_u.xfer(1'b1, idx, wd, rd);
			if (idx inside {[2:3]}) shadow[idx] = wd;
			if (idx == IDX_ADVERTISE) shadow[idx] = wd & 16'h2dff;
			mac_u.xfer(1'b0, idx, 16'h0, rd);
			chk("read back", rd, shadow[idx]);
			chk("hit", 16'(mgmtHit), 16'(idx inside {[1:4]}));
		end
		// Every pause code against random partner abilities
		for (i = 0; i < 8; i++) begin
			wd = 16'($random(seed));
			mac_u.xfer(1'b1, IDX_ADVERTISE, {4'h0, i[1:0], 10'h1e1}, rd);
			partnerSym <= wd[0];
			partnerAsym <= wd[1];
			anComplete <= 1'b1;
			repeat (4) @(posedge mclk);
			chk("advert", advertWord, {4'h0, i[1:0], 10'h1e1});
			chk("pause", 16'(pauseResolved), 16'(expPause(i[1:0], wd[0], wd[1])));
			mac_u.xfer(1'b0, IDX_BASIC_STATUS, 16'h0, rd);
			chk("autoneg done", rd, 16'h782d);
			anComplete <= 1'b0;
			repeat (3) @(posedge mclk);
		end
		testDone();
	end
endmodule : phy_status_id_advert_regs_tb
`default_nettype wire

// ### testbench/psar_mac_model.sv
// MAC side management access model
`timescale 1ns/1ns
`default_nettype none
module psar_mac_model (
	input wire logic mclk,
	input wire logic mgmtAck,
	input wire logic [15:0] mgmtRdata,
	output var logic mgmtRead,
	output var logic mgmtWrite,
	output var logic [4:0] mgmtIndex,
	output var logic [15:0] mgmtWdata
);
	// Idle bus at time zero
	initial begin
		mgmtRead = 1'b0;
		mgmtWrite = 1'b0;
		mgmtIndex = 5'h00;
		mgmtWdata = 16'h0;
	end
	task automatic xfer(input logic wr, input logic [4:0] idx,
		input logic [15:0] wd, output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge mclk);
		mgmtRead <= !wr;
		mgmtWrite <= wr;
		mgmtIndex <= idx;
		mgmtWdata <= wd;
		do @(posedge mclk); while (mgmtAck !== 1'b1 && ++n < 8);
		rd = mgmtRdata;
		mgmtRead <= 1'b0;
		mgmtWrite <= 1'b0;
		mgmtWdata <= ~wd;
	endtask : xfer
endmodule : psar_mac_model
`default_nettype wire

// ### testbench/psar_regs_asserts.sv
// Port assertions for the PHY status and advertisement registers
`timescale 1ns/1ns
`default_nettype none
module psar_regs_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic mgmtRead,
	input wire logic mgmtWrite,
	input wire logic [4:0] mgmtIndex,
	input wire logic [15:0] mgmtWdata,
	input wire logic anComplete,
	input wire logic remoteFault,
	input wire logic linkUp,
	input wire logic jabber,
	input wire logic partnerSym,
	input wire logic partnerAsym,
	input wire logic [15:0] mgmtRdata,
	input wire logic mgmtAck,
	input wire logic mgmtHit,
	input wire logic [15:0] advertWord,
	input wire logic [1:0] pauseResolved
);
	import psar_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic stRd;
	wire logic stAck;
	// Status read seen one edge ago
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) stRd <= 1'b0;
		else stRd <= mgmtRead && mgmtIndex == IDX_BASIC_STATUS;
	end
	assign stAck = mgmtAck && stRd;
	AST_FIXED_BITS: assert property (stAck |-> mgmtRdata[15:11] == 5'h0f &&
		mgmtRdata[10:6] == 5'h00 && mgmtRdata[3] && mgmtRdata[0])
		else $error("fixed status bits wrong");
	AST_AN_DONE: assert property (stAck |-> mgmtRdata[5] == $past(anComplete, 2))
		else $error("autoneg done bit wrong");
	AST_FAULT_LATCH: assert property (stAck && $past(remoteFault, 2) |-> mgmtRdata[4])
		else $error("remote fault not latched");
	AST_LINK_LATCH: assert property (stAck && !$past(linkUp, 2) |-> !mgmtRdata[2])
		else $error("link drop not latched");
	AST_JABBER_LATCH: assert property (stAck && $past(jabber, 2) |-> mgmtRdata[1])
		else $error("jabber not latched");
	AST_ADV_WRITE: assert property (mgmtAck && $past(mgmtWrite) && !$past(mgmtRead) &&
		$past(mgmtIndex) == IDX_ADVERTISE |=>
		advertWord == ($past(mgmtWdata, 2) & 16'h2dff))
		else $error("advert write wrong");
	AST_UNMAPPED: assert property (mgmtAck && $past(mgmtRead) &&
		!($past(mgmtIndex) inside {[1:4]}) |-> !mgmtHit && mgmtRdata == 16'h0)
		else $error("unmapped read wrong");
	AST_PAUSE_ONE: assert property (pauseResolved != PAUSE_BOTH)
		else $error("both pause kinds resolved");
endmodule : psar_regs_chk
bind psar_regs psar_regs_chk chk_u (.mclk, .rst_n, .mgmtRead, .mgmtWrite,
	.mgmtIndex, .mgmtWdata, .anComplete, .remoteFault, .linkUp, .jabber,
	.partnerSym, .partnerAsym, .mgmtRdata, .mgmtAck, .mgmtHit, .advertWord,
	.pauseResolved);
`default_nettype wire
